// file: hdl/prd_pkg.sv
// Constants, register map and types for the packet DMA and radio interface.
// Assumes a 16-bit word memory and a 6-bit word-addressed register port.
package prd_pkg;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned NUM_CH = 2;
  // Channel roles: channel 0 takes data from the radio, channel 1 feeds it.
  localparam logic CH_RX = 1'b0;
  localparam logic CH_TX = 1'b1;
  // Register offsets (word index on the register port).
  localparam logic [ADDR_W-1:0] OFS_CH0_BASE = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_CH1_BASE = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RADIO_CFG = 6'h09;
  // Register fields inside a channel block, selected by address bits 1:0.
  localparam logic [1:0] FLD_ADDR = 2'h0;
  localparam logic [1:0] FLD_COUNT = 2'h1;
  localparam logic [1:0] FLD_DATA = 2'h2;
  localparam logic [1:0] FLD_CTRL = 2'h3;
  // Status/control bit positions.
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_OVERRUN_BIT = 1;
  localparam int unsigned CTRL_CRC_ERR_BIT = 2;
  localparam int unsigned CTRL_ACTIVE_BIT = 3;
  localparam int unsigned CTRL_DIR_BIT = 4;
  // Radio configuration fields.
  localparam int unsigned CFG_POWER_LSB = 0;
  localparam int unsigned CFG_POWER_W = 4;
  localparam int unsigned CFG_FREQ_LSB = 4;
  localparam int unsigned CFG_FREQ_W = 8;
  localparam int unsigned CFG_RATE_LSB = 12;
  localparam int unsigned CFG_RATE_W = 4;
  // Error check: residue over the whole packet including its check word.
  localparam logic [DATA_W-1:0] CRC_POLY = 16'h1021;
  localparam logic [DATA_W-1:0] CRC_INIT = 16'hffff;
  localparam logic [DATA_W-1:0] CRC_GOOD = 16'h0000;
  // Bits per word, expressed as the last index of the bit counter.
  localparam logic [3:0] BIT_LAST = 4'hf;
  // Reset values.
  localparam logic [DATA_W-1:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_BITS = 4'h0;
  typedef enum logic {ARB_IDLE, ARB_BUSY} prd_arb_state_t;
endpackage

// file: hdl/prd_dma_radio.sv
// Packet DMA channels, memory cycle arbiter and serial radio interface.
// Assumes a processor memory request level, a memory that ends each DMA
// cycle with a one-cycle done pulse, and radio pins asynchronous to clk_sys_i.
//
// Function
// - Processor memory request always wins arbitration
// - DMA cycles only when processor idle
// - Channel bids accepted at any time
// - Competing channels served round robin
// - Unserviced word at next word is overrun
// - Channels share address, count, data, control
// - Receive count loaded from packet length word
// - Sync interrupts, then writes each received word
// - Receive count zero: interrupt, drop enable
// - Transmit loaded by processor, then reads memory
// - Transmit count zero interrupts the processor
// - Receive data accepted only while enabled
// - Shift data and check while sync high
// - Every 16 bits latch word, request write
// - Check verdict kept in readable error bit
// - Dropping receive enable aborts, allows reinit
// - Radio settings taken at transmit enable rise
// - Each transmit clock requests the next bit
// - Whole packet streamed from memory words
// - Transmit enable drops at packet end
// - Interrupt status has one bit per channel
`timescale 1ns/1ps
`default_nettype none
module prd_dma_radio
  import prd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic irq_o,
  // Processor memory request.
  input wire logic cpu_mem_req_i,
  output logic cpu_grant_o,
  // Memory port for DMA cycles.
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [DATA_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic mem_done_i,
  // Radio receive side.
  input wire logic rx_data_i,
  input wire logic rx_clk_i,
  input wire logic rx_sync_i,
  output logic rx_enable_o,
  // Radio transmit side.
  input wire logic tx_clk_i,
  output logic tx_data_o,
  output logic transmit_enable_line_o,
  output logic [CFG_POWER_W-1:0] radio_power_o,
  output logic [CFG_FREQ_W-1:0] radio_freq_o,
  output logic [CFG_RATE_W-1:0] radio_rate_o
);

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic ch,
                                   input logic [1:0] fld);
    reg_hit = (a[ADDR_W-1:3] == OFS_CH0_BASE[ADDR_W-1:3]) && (a[2] == ch) &&
              (a[1:0] == fld);
  endfunction

  function automatic logic [DATA_W-1:0] crc_step(input logic [DATA_W-1:0] c,
                                                 input logic b);
    crc_step = {c[DATA_W-2:0], 1'b0} ^ ((c[DATA_W-1] ^ b) ? CRC_POLY : RST_WORD);
  endfunction

  // Pin synchronisers: three stages, a level counts once stages two and three agree.
  logic [3:0] pin_raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] lvl_q;
  logic [3:0] rise;
  assign pin_raw = {tx_clk_i, rx_sync_i, rx_clk_i, rx_data_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          s3_q[gi] <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            lvl_q[gi] <= s3_q[gi];
          end
        end
      end
      assign rise[gi] = (s2_q[gi] == s3_q[gi]) && s3_q[gi] && !lvl_q[gi];
    end
  endgenerate

  logic rx_bit;
  logic rx_clk_rise;
  logic rx_sync_lvl;
  logic rx_sync_rise;
  logic tx_clk_rise;
  assign rx_bit = lvl_q[0];
  assign rx_clk_rise = rise[1];
  assign rx_sync_lvl = lvl_q[2];
  assign rx_sync_rise = rise[2];
  assign tx_clk_rise = rise[3];

  // Channel registers, identical for both roles.
  logic [DATA_W-1:0] addr_q [NUM_CH];
  logic [DATA_W-1:0] count_q [NUM_CH];
  logic [DATA_W-1:0] data_q [NUM_CH];
  logic [NUM_CH-1:0] en_q;
  logic [NUM_CH-1:0] ovr_q;
  logic [NUM_CH-1:0] ctrl_wr;
  logic [NUM_CH-1:0] dma_done;
  logic [NUM_CH-1:0] ev_done;
  logic [NUM_CH-1:0] ev_ovr;
  logic [NUM_CH-1:0] ev_start;
  logic [NUM_CH-1:0] bid;

  // Arbiter state.
  prd_arb_state_t arb_q;
  logic gnt_q;
  logic rr_last_q;
  logic pick;

  // Receive state.
  logic [DATA_W-1:0] rx_sh_q;
  logic [DATA_W-1:0] crc_q;
  logic [3:0] rx_bits_q;
  logic rx_pend_q;
  logic rx_len_q;
  logic rx_active_q;
  logic crc_err_q;
  logic rx_go;
  logic rx_word;
  logic rx_reinit;
  logic [DATA_W-1:0] rx_word_val;

  // Transmit state.
  logic [DATA_W-1:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic tx_full_q;
  logic tx_data_q;
  logic tx_en_prev_q;
  logic tx_idle;
  logic tx_take;
  logic [DATA_W-1:0] cfg_q;
  logic [NUM_CH-1:0] int_q;
  logic [DATA_W-1:0] rdata_q;

  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      assign ctrl_wr[gi] = reg_wr_i && reg_hit(reg_addr_i, gi[0], FLD_CTRL);
      assign dma_done[gi] = (arb_q == ARB_BUSY) && mem_done_i && (gnt_q == gi[0]);

      // Address register: loaded by software, stepped after each DMA cycle.
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          addr_q[gi] <= RST_WORD;
        end else if (reg_wr_i && reg_hit(reg_addr_i, gi[0], FLD_ADDR)) begin
          addr_q[gi] <= reg_wdata_i;
        end else if (dma_done[gi]) begin
          addr_q[gi] <= addr_q[gi] + 16'h0001;
        end
      end

      // Overrun flag: set wins over the re-initialising control write.
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          ovr_q[gi] <= 1'b0;
        end else if (ev_ovr[gi]) begin
          ovr_q[gi] <= 1'b1;
        end else if (ctrl_wr[gi]) begin
          ovr_q[gi] <= 1'b0;
        end
      end

      // Interrupt status: one sticky bit per channel, cleared by writing one.
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          int_q[gi] <= 1'b0;
        end else if (ev_start[gi] || ev_done[gi]) begin
          int_q[gi] <= 1'b1;
        end else if (reg_wr_i && reg_addr_i == OFS_INT_STATUS && reg_wdata_i[gi]) begin
          int_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Memory arbiter.
  assign bid[CH_RX] = rx_pend_q && en_q[CH_RX];
  assign bid[CH_TX] = en_q[CH_TX] && !tx_full_q && (count_q[CH_TX] != RST_WORD);
  assign pick = (bid[CH_RX] && bid[CH_TX]) ? !rr_last_q : bid[CH_TX];
  assign cpu_grant_o = cpu_mem_req_i && (arb_q == ARB_IDLE);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arb_q <= ARB_IDLE;
      gnt_q <= CH_RX;
      rr_last_q <= CH_TX;
      mem_addr_o <= RST_WORD;
      mem_we_o <= 1'b0;
    end else begin
      case (arb_q)
        ARB_IDLE: begin
          if (!cpu_mem_req_i && (bid != '0)) begin
            arb_q <= ARB_BUSY;
            gnt_q <= pick;
            mem_addr_o <= addr_q[pick];
            mem_we_o <= (pick == CH_RX);
          end
        end
        ARB_BUSY: begin
          if (mem_done_i) begin
            arb_q <= ARB_IDLE;
            rr_last_q <= gnt_q;
          end
        end
        default: arb_q <= ARB_IDLE;
      endcase
    end
  end
  assign mem_req_o = (arb_q == ARB_BUSY);
  assign mem_wdata_o = data_q[CH_RX];

  // Receive path.
  assign rx_reinit = ctrl_wr[CH_RX];
  assign rx_go = en_q[CH_RX] && rx_sync_lvl && rx_clk_rise;
  assign rx_word = rx_go && (rx_bits_q == BIT_LAST);
  assign rx_word_val = {rx_sh_q[DATA_W-2:0], rx_bit};
  assign ev_start[CH_RX] = en_q[CH_RX] && rx_sync_rise;
  assign ev_ovr[CH_RX] = rx_word && rx_pend_q && !dma_done[CH_RX];
  assign ev_done[CH_RX] = dma_done[CH_RX] &&
                          (rx_len_q ? (count_q[CH_RX] == 16'h0001)
                                    : (data_q[CH_RX] == RST_WORD));

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_sh_q <= RST_WORD;
      rx_bits_q <= RST_BITS;
      crc_q <= CRC_INIT;
    end else if (rx_reinit || ev_start[CH_RX]) begin
      rx_bits_q <= RST_BITS;
      crc_q <= CRC_INIT;
    end else if (rx_go) begin
      rx_sh_q <= rx_word_val;
      crc_q <= crc_step(crc_q, rx_bit);
      rx_bits_q <= rx_bits_q + 4'h1;
    end
  end

  // Word latch and write request; a new word wins over the clearing done.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q[CH_RX] <= RST_WORD;
      rx_pend_q <= 1'b0;
    end else if (rx_reinit) begin
      rx_pend_q <= 1'b0;
    end else if (rx_word) begin
      data_q[CH_RX] <= rx_word_val;
      rx_pend_q <= 1'b1;
    end else if (dma_done[CH_RX]) begin
      rx_pend_q <= 1'b0;
    end
  end

  // Receive word counter: the first word carries the length of the rest.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q[CH_RX] <= RST_WORD;
      rx_len_q <= 1'b0;
    end else if (rx_reinit || ev_start[CH_RX]) begin
      rx_len_q <= 1'b0;
      if (reg_wr_i && reg_hit(reg_addr_i, CH_RX, FLD_COUNT)) begin
        count_q[CH_RX] <= reg_wdata_i;
      end
    end else if (reg_wr_i && reg_hit(reg_addr_i, CH_RX, FLD_COUNT)) begin
      count_q[CH_RX] <= reg_wdata_i;
    end else if (dma_done[CH_RX]) begin
      if (!rx_len_q) begin
        rx_len_q <= 1'b1;
        count_q[CH_RX] <= data_q[CH_RX];
      end else begin
        count_q[CH_RX] <= count_q[CH_RX] - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_active_q <= 1'b0;
      crc_err_q <= 1'b0;
    end else if (ev_done[CH_RX]) begin
      rx_active_q <= 1'b0;
      crc_err_q <= (crc_q != CRC_GOOD);
    end else if (rx_reinit || ev_start[CH_RX]) begin
      rx_active_q <= ev_start[CH_RX];
      crc_err_q <= 1'b0;
    end
  end

  // Channel enables; software writes re-initialise, hardware ends packets.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en_q <= '0;
    end else begin
      if (ctrl_wr[CH_RX]) begin
        en_q[CH_RX] <= reg_wdata_i[CTRL_ENABLE_BIT];
      end else if (ev_done[CH_RX]) begin
        en_q[CH_RX] <= 1'b0;
      end
      if (ctrl_wr[CH_TX]) begin
        en_q[CH_TX] <= reg_wdata_i[CTRL_ENABLE_BIT];
      end else if (tx_idle) begin
        en_q[CH_TX] <= 1'b0;
      end
    end
  end
  assign rx_enable_o = en_q[CH_RX];

  // Transmit path.
  assign ev_start[CH_TX] = 1'b0;
  assign ev_done[CH_TX] = dma_done[CH_TX] && (count_q[CH_TX] == 16'h0001);
  assign tx_take = en_q[CH_TX] && tx_clk_rise && (tx_bits_q == RST_BITS);
  assign ev_ovr[CH_TX] = tx_take && !tx_full_q && (count_q[CH_TX] != RST_WORD);
  assign tx_idle = en_q[CH_TX] && tx_en_prev_q && (count_q[CH_TX] == RST_WORD) &&
                   !tx_full_q && (tx_bits_q == RST_BITS);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_q[CH_TX] <= RST_WORD;
    end else if (reg_wr_i && reg_hit(reg_addr_i, CH_TX, FLD_COUNT)) begin
      count_q[CH_TX] <= reg_wdata_i;
    end else if (dma_done[CH_TX]) begin
      count_q[CH_TX] <= count_q[CH_TX] - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      data_q[CH_TX] <= RST_WORD;
      tx_full_q <= 1'b0;
    end else if (ctrl_wr[CH_TX]) begin
      tx_full_q <= 1'b0;
    end else if (dma_done[CH_TX]) begin
      data_q[CH_TX] <= mem_rdata_i;
      tx_full_q <= 1'b1;
    end else if (tx_take) begin
      tx_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_sh_q <= RST_WORD;
      tx_bits_q <= RST_BITS;
      tx_data_q <= 1'b0;
    end else if (ctrl_wr[CH_TX]) begin
      tx_bits_q <= RST_BITS;
      tx_data_q <= 1'b0;
    end else if (tx_take) begin
      if (tx_full_q) begin
        tx_data_q <= data_q[CH_TX][DATA_W-1];
        tx_sh_q <= {data_q[CH_TX][DATA_W-2:0], 1'b0};
        tx_bits_q <= 4'h1;
      end else begin
        tx_data_q <= 1'b0;
      end
    end else if (en_q[CH_TX] && tx_clk_rise) begin
      tx_data_q <= tx_sh_q[DATA_W-1];
      tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
      tx_bits_q <= tx_bits_q + 4'h1;
    end
  end
  assign tx_data_o = tx_data_q;
  assign transmit_enable_line_o = en_q[CH_TX];

  // Radio settings reach the radio on the rising edge of transmit enable.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_en_prev_q <= 1'b0;
      radio_power_o <= '0;
      radio_freq_o <= '0;
      radio_rate_o <= '0;
    end else begin
      tx_en_prev_q <= en_q[CH_TX];
      if (en_q[CH_TX] && !tx_en_prev_q) begin
        radio_power_o <= cfg_q[CFG_POWER_LSB +: CFG_POWER_W];
        radio_freq_o <= cfg_q[CFG_FREQ_LSB +: CFG_FREQ_W];
        radio_rate_o <= cfg_q[CFG_RATE_LSB +: CFG_RATE_W];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= RST_WORD;
    end else if (reg_wr_i && reg_addr_i == OFS_RADIO_CFG) begin
      cfg_q <= reg_wdata_i;
    end
  end

  // Register read port: data stand in the cycle after the strobe only.
  function automatic logic [DATA_W-1:0] ctrl_view(input logic ch);
    logic [DATA_W-1:0] v;
    v = RST_WORD;
    v[CTRL_ENABLE_BIT] = en_q[ch];
    v[CTRL_OVERRUN_BIT] = ovr_q[ch];
    v[CTRL_CRC_ERR_BIT] = (ch == CH_RX) && crc_err_q;
    v[CTRL_ACTIVE_BIT] = (ch == CH_RX) ? rx_active_q : en_q[CH_TX];
    v[CTRL_DIR_BIT] = ch;
    ctrl_view = v;
  endfunction

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= RST_WORD;
    end else if (!reg_rd_i) begin
      rdata_q <= RST_WORD;
    end else if (reg_addr_i == OFS_INT_STATUS) begin
      rdata_q <= {{(DATA_W-NUM_CH){1'b0}}, int_q};
    end else if (reg_addr_i == OFS_RADIO_CFG) begin
      rdata_q <= cfg_q;
    end else if (reg_addr_i[ADDR_W-1:3] != OFS_CH0_BASE[ADDR_W-1:3]) begin
      rdata_q <= RST_WORD;
    end else begin
      case (reg_addr_i[1:0])
        FLD_ADDR: rdata_q <= addr_q[reg_addr_i[2]];
        FLD_COUNT: rdata_q <= count_q[reg_addr_i[2]];
        FLD_DATA: rdata_q <= data_q[reg_addr_i[2]];
        FLD_CTRL: rdata_q <= ctrl_view(reg_addr_i[2]);
        default: rdata_q <= RST_WORD;
      endcase
    end
  end
  assign reg_rdata_o = rdata_q;
  assign irq_o = |int_q;

endmodule
`default_nettype wire

// file: tb/prd_dma_radio_assertions.sv
// Checker for the arbiter, register read port and radio control outputs.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module prd_dma_radio_assertions
  import prd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic irq_o,
  // Memory arbitration.
  input wire logic cpu_mem_req_i,
  input wire logic cpu_grant_o,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [DATA_W-1:0] mem_addr_o,
  input wire logic mem_done_i,
  // Radio control.
  input wire logic rx_enable_o,
  input wire logic transmit_enable_line_o,
  input wire logic [CFG_POWER_W-1:0] radio_power_o,
  input wire logic [CFG_FREQ_W-1:0] radio_freq_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  chk_cpu_wins: assert property (cpu_mem_req_i && !mem_req_o |-> cpu_grant_o)
    else $error("Processor not granted.");
  chk_steal_idle: assert property ($rose(mem_req_o) |-> !$past(cpu_mem_req_i))
    else $error("DMA started over processor.");
  chk_one_grant: assert property (mem_req_o |-> !cpu_grant_o)
    else $error("Two grants at once.");
  chk_grant_held: assert property (mem_req_o && !mem_done_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("DMA cycle not held.");
  chk_grant_ends: assert property (mem_req_o && mem_done_i |=> !mem_req_o)
    else $error("DMA cycle not ended.");
  chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("Read data outside read.");
  chk_irq_status: assert property (reg_rd_i && reg_addr_i == OFS_INT_STATUS |=>
    (reg_rdata_o[1:0] != 2'h0) == $past(irq_o))
    else $error("Interrupt and status differ.");
  chk_cfg_steady: assert property (transmit_enable_line_o && $past(transmit_enable_line_o, 3)
    |-> $stable({radio_power_o, radio_freq_o}))
    else $error("Radio settings moved.");
  chk_rx_write: assert property ($rose(mem_req_o) && mem_we_o |-> rx_enable_o)
    else $error("Write without receive.");
  chk_tx_read: assert property ($rose(mem_req_o) && !mem_we_o |-> transmit_enable_line_o)
    else $error("Read without transmit.");
endmodule
bind prd_dma_radio prd_dma_radio_assertions prd_dma_radio_assertions_i (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
  .cpu_mem_req_i(cpu_mem_req_i), .cpu_grant_o(cpu_grant_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_done_i(mem_done_i),
  .rx_enable_o(rx_enable_o), .transmit_enable_line_o(transmit_enable_line_o),
  .radio_power_o(radio_power_o), .radio_freq_o(radio_freq_o)
);
`default_nettype wire

// file: tb/prd_radio_model.sv
// Radio modem model: serial receive source and transmit bit sink.
// Assumes the bench calls its tasks; link clocks stand low between frames.
`timescale 1ns/1ps
`default_nettype none
module prd_radio_model (
  // Controls from the interface.
  input wire logic rx_enable_i,
  input wire logic transmit_enable_i,
  input wire logic tx_data_i,
  // Lines to the interface.
  output logic rx_data_o,
  output logic rx_clk_o,
  output logic rx_sync_o,
  output logic tx_clk_o
);
  initial begin
    rx_data_o = 1'b0;
    rx_clk_o = 1'b0;
    rx_sync_o = 1'b0;
    tx_clk_o = 1'b0;
  end
  // Sync is released once the receiver is disabled.
  always @(negedge rx_enable_i) begin
    rx_sync_o = 1'b0;
  end
  task automatic sync_on();
    rx_sync_o = 1'b1;
    #200;
  endtask
  task automatic sync_off();
    rx_sync_o = 1'b0;
    rx_data_o = ~rx_data_o;
  endtask
  // Bits go out first bit high order, steady around each rising clock.
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      rx_data_o = w[i];
      #100 rx_clk_o = 1'b1;
      #100 rx_clk_o = 1'b0;
    end
  endtask
  // Clocks return after a settling delay and stop once enable drops.
  task automatic run_tx(input int nbits, output logic [31:0] bits);
    bits = '0;
    #1000;
    for (int i = 0; i < nbits && transmit_enable_i; i++) begin
      tx_clk_o = 1'b1;
      #100 tx_clk_o = 1'b0;
      #99 bits = {bits[30:0], tx_data_i};
      #1;
    end
  endtask
endmodule
`default_nettype wire

// file: tb/prd_dma_radio_tb.sv
// Self-checking bench for the packet DMA and radio interface.
// Assumes the package, the radio model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module prd_dma_radio_tb;
  import prd_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic cpu_mem_req_i = 1'b0;
  logic [DATA_W-1:0] mem_rdata_i = '0;
  logic mem_done_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o, mem_addr_o, mem_wdata_o;
  logic irq_o, cpu_grant_o, mem_req_o, mem_we_o, rx_enable_o, tx_data_o, tx_en;
  logic rx_data_i, rx_clk_i, rx_sync_i, tx_clk_i;
  logic [CFG_POWER_W-1:0] radio_power_o;
  logic [CFG_FREQ_W-1:0] radio_freq_o;
  logic [CFG_RATE_W-1:0] radio_rate_o;
  logic [DATA_W-1:0] wlog_a[$];
  logic [DATA_W-1:0] wlog_d[$];
  logic [1:0] mem_wait = 2'h0;
  int err_total = 0;
  int cmp_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  prd_dma_radio prd_dma_radio_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .cpu_mem_req_i(cpu_mem_req_i), .cpu_grant_o(cpu_grant_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_rdata_i(mem_rdata_i), .mem_done_i(mem_done_i), .rx_data_i(rx_data_i),
    .rx_clk_i(rx_clk_i), .rx_sync_i(rx_sync_i), .rx_enable_o(rx_enable_o),
    .tx_clk_i(tx_clk_i), .tx_data_o(tx_data_o), .transmit_enable_line_o(tx_en),
    .radio_power_o(radio_power_o), .radio_freq_o(radio_freq_o), .radio_rate_o(radio_rate_o));
  prd_radio_model prd_radio_model_i (.rx_enable_i(rx_enable_o), .transmit_enable_i(tx_en),
    .tx_data_i(tx_data_o), .rx_data_o(rx_data_i), .rx_clk_o(rx_clk_i),
    .rx_sync_o(rx_sync_i), .tx_clk_o(tx_clk_i));
  // Memory ends each DMA cycle after three wait cycles and logs writes.
  always @(posedge clk_sys_i) begin
    mem_done_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (mem_req_o && !mem_done_i) begin
      mem_wait <= mem_wait + 2'h1;
      if (mem_wait == 2'h2) begin
        mem_done_i <= 1'b1;
        mem_wait <= 2'h0;
        mem_rdata_i <= mem_addr_o ^ 16'hc3a5;
        if (mem_we_o) begin
          wlog_a.push_back(mem_addr_o);
          wlog_d.push_back(mem_wdata_o);
        end
      end
    end
  end
  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_sig(input int sel, input logic v);
    int n;
    n = 0;
    while (n < 4000 && (sel == 0 ? rx_enable_o : sel == 1 ? tx_en : irq_o) !== v) begin
      @(posedge clk_sys_i);
      n++;
    end
    #1;
    if (n == 4000) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, ~v, v);
      finish_test();
    end
  endtask
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
  task automatic t_reset();
    logic [15:0] d;
    chk({15'h0, mem_req_o}, 16'h0000);
    reg_rd(OFS_CH0_BASE + 6'h3, d);
    chk(d, 16'h0000);
    reg_rd(OFS_CH1_BASE + 6'h3, d);
    chk(d, 16'h0010);
    reg_rd(6'h3f, d);
    chk(d, 16'h0000);
    $display("Test reset done");
  endtask
  task automatic t_overrun();
    logic [15:0] d;
    @(posedge clk_sys_i);
    cpu_mem_req_i <= 1'b1;
    reg_wr(OFS_CH0_BASE, 16'h0300);
    reg_wr(OFS_CH0_BASE + 6'h3, 16'h0001);
    prd_radio_model_i.sync_on();
    prd_radio_model_i.send_word(16'h0005);
    prd_radio_model_i.send_word(16'h1111);
    prd_radio_model_i.send_word(16'h2222);
    chk({mem_req_o, cpu_grant_o}, 16'h0001);
    reg_rd(OFS_CH0_BASE + 6'h3, d);
    chk({15'h0, d[CTRL_OVERRUN_BIT]}, 16'h0001);
    @(posedge clk_sys_i);
    cpu_mem_req_i <= 1'b0;
    repeat (40) @(posedge clk_sys_i);
    reg_rd(OFS_CH0_BASE + 6'h3, d);
    chk({15'h0, d[CTRL_OVERRUN_BIT]}, 16'h0001);
    reg_wr(OFS_CH0_BASE + 6'h3, 16'h0000);
    chk({rx_enable_o, rx_sync_i}, 16'h0000);
    reg_rd(OFS_CH0_BASE + 6'h3, d);
    chk({15'h0, d[CTRL_OVERRUN_BIT]}, 16'h0000);
    prd_radio_model_i.sync_off();
    reg_wr(OFS_INT_STATUS, 16'h0003);
    $display("Test overrun done");
  endtask
  task automatic t_rx(input logic bad);
    logic [15:0] d;
    logic [15:0] w [3];
    w[0] = 16'h0002;
    w[1] = 16'ha5c3;
    w[2] = crc16(crc16(CRC_INIT, w[0]), w[1]) ^ {15'h0, bad};
    wlog_a.delete();
    wlog_d.delete();
    reg_wr(OFS_CH0_BASE, 16'h0100);
    reg_wr(OFS_CH0_BASE + 6'h3, 16'h0001);
    chk({15'h0, rx_enable_o}, 16'h0001);
    prd_radio_model_i.sync_on();
    wait_sig(2, 1'b1);
    reg_rd(OFS_INT_STATUS, d);
    chk(d, 16'h0001);
    reg_wr(OFS_INT_STATUS, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      prd_radio_model_i.send_word(w[i]);
    end
    wait_sig(0, 1'b0);
    chk({15'h0, irq_o}, 16'h0001);
    chk(16'(wlog_a.size()), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      chk(wlog_a[i], 16'h0100 + 16'(i));
      chk(wlog_d[i], w[i]);
    end
    reg_rd(OFS_CH0_BASE + 6'h3, d);
    chk({15'h0, d[CTRL_CRC_ERR_BIT]}, {15'h0, bad});
    prd_radio_model_i.sync_off();
    reg_wr(OFS_INT_STATUS, 16'h0003);
    $display("Test receive done");
  endtask
  task automatic t_tx();
    logic [15:0] d;
    logic [31:0] bits;
    @(posedge clk_sys_i);
    cpu_mem_req_i <= 1'b1;
    reg_wr(OFS_RADIO_CFG, 16'h5a3c);
    reg_wr(OFS_CH1_BASE + 6'h1, 16'h0002);
    reg_wr(OFS_CH1_BASE, 16'h0200);
    reg_wr(OFS_CH1_BASE + 6'h3, 16'h0001);
    wait_sig(1, 1'b1);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk({radio_rate_o, radio_freq_o, radio_power_o}, 16'h5a3c);
    chk({15'h0, mem_req_o}, 16'h0000);
    @(posedge clk_sys_i);
    cpu_mem_req_i <= 1'b0;
    prd_radio_model_i.run_tx(32, bits);
    chk(bits[31:16], 16'h0200 ^ 16'hc3a5);
    chk(bits[15:0], 16'h0201 ^ 16'hc3a5);
    wait_sig(1, 1'b0);
    chk({15'h0, tx_clk_i}, 16'h0000);
    reg_rd(OFS_INT_STATUS, d);
    chk(d & 16'h0002, 16'h0002);
    $display("Test transmit done");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_overrun();
    t_rx(1'b0);
    t_rx(1'b1);
    t_tx();
    finish_test();
  end
  initial begin
    #2000000;
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
